// ===== verification/fnvc_erase_programmer.sv
// Model of the external programmer that drives the erase pin.
// Assumes the bench calls hold_pin right after a rising edge of sys_clk.
module fnvc_erase_programmer (
  // Clock.
  input wire logic sys_clk,
  // Erase pin.
  output logic erasePin
);
  // ====================
  // Pin drive
  // The pin has a pull-down, so the idle level is low.
  initial erasePin = 1'b0;
  // A hold shorter than the qualification time is only made on purpose.
  task automatic hold_pin(input int n);
    erasePin <= 1'b1;
    repeat (n) @(posedge sys_clk);
    erasePin <= 1'b0;
  endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench of the flash non-volatile configuration controller.
// Assumes fnvc_params.svh on the include path and shortened timing counts.
`include "fnvc_params.svh"
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin nMismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fnvc_pkg::*;
  // ====================
  // Signals
  logic sys_clk;
  logic arst_n;
  logic erasePin;
  fnvc_bus_req_t busReq;
  fnvc_bus_rsp_t busRsp;
  fnvc_fetch_t fetch;
  fnvc_region_t region;
  logic brownoutDetectorEn;
  logic brownoutResetEn;
  logic readProtected;
  logic [31:0] lockBits;
  logic [15:0] calibBits;
  int nMismatch = 0;
  int samplesChecked = 0;
  logic [27:0] mapAddr [7] = '{28'h0000000, 28'h0000000, 28'h0100000, 28'h0200000,
    28'h03FFFFF, 28'h0400000, 28'hFFFFFFF};
  logic [3:0] mapExp [7] = '{4'h2, 4'h4, 4'h8, 4'h4, 4'h2, 4'h1, 4'h1};
  // ====================
  // Instances
  // Program time is kept long enough to see a refused command while busy.
  fnvc_nvm_ctrl #(.PROG_CYCLES(40), .PROG_NOERASE_CYCLES(4), .ERASE_CYCLES(10),
    .ERASE_PIN_CYCLES(20)) i_fnvc_nvm_ctrl (
    .sys_clk(sys_clk), .arst_n(arst_n), .busReq(busReq), .busRsp(busRsp),
    .erasePin(erasePin), .fetch(fetch), .region(region),
    .brownoutDetectorEn(brownoutDetectorEn), .brownoutResetEn(brownoutResetEn),
    .readProtected(readProtected), .lockBits(lockBits), .calibBits(calibBits));
  fnvc_erase_programmer i_fnvc_erase_programmer (.sys_clk(sys_clk), .erasePin(erasePin));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ====================
  // Tasks
  task automatic finish_test();
    $display("Mismatches %0d of %0d checks", nMismatch, samplesChecked);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One bus access; an edge passes after release so requests never collide.
  task automatic xfer(input logic [3:0] a, input logic wr, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    busReq <= '{address: a, read: !wr, write: wr, writedata: d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (busRsp.waitrequest !== 1'b0 && n < 40);
    q = busRsp.readdata;
    busReq <= '0;
    @(posedge sys_clk);
    if (n >= 40) begin
      nMismatch++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic chkRd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    `CHK("readdata", e, q)
  endtask
  // Polls status until busy and erase armed are both clear; protection is ignored.
  task automatic idle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      xfer(`FNVC_OFF_STATUS, 1'b0, 32'h0, q);
      n++;
    end while ((q & 32'h0000_0005) !== 32'h0000_0000 && n < 200);
    if (n >= 200) begin
      nMismatch++;
      finish_test();
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] arg);
    wr(`FNVC_OFF_CMD, {arg, op});
    idle();
  endtask
  task automatic chkMap(input logic [27:0] a, input logic rm, input logic [3:0] e);
    fetch <= '{addr: a, remapped: rm};
    repeat (2) @(posedge sys_clk);
    `CHK("region", e, region)
  endtask
  // ====================
  // Sequence
  initial begin
    arst_n = 1'b0;
    busReq = '0;
    fetch = '0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chkRd(`FNVC_OFF_NVBITS, 32'h0);
    chkRd(`FNVC_OFF_STATUS, 32'h0);
    chkRd(4'h7, 32'h0);
    wr(`FNVC_OFF_CALIB, 32'h0);
    chkRd(`FNVC_OFF_CALIB, 32'h5A3C);
    `CHK("calib", 16'h5A3C, calibBits)
    for (int i = 0; i < 7; i++) begin
      chkMap(mapAddr[i], i == 1, mapExp[i]);
    end
    cmd(`FNVC_CMD_SET_NVBIT, 24'h0);
    `CHK("detector", 1'b1, brownoutDetectorEn)
    `CHK("reset enable", 1'b0, brownoutResetEn)
    cmd(`FNVC_CMD_SET_NVBIT, 24'h1);
    cmd(`FNVC_CMD_SET_NVBIT, 24'h2);
    `CHK("reset enable", 1'b1, brownoutResetEn)
    chkRd(`FNVC_OFF_NVBITS, 32'h7);
    chkMap(28'h0000000, 1'b0, 4'h8);
    chkMap(28'h0000000, 1'b1, 4'h4);
    cmd(`FNVC_CMD_CLR_NVBIT, 24'h2);
    chkRd(`FNVC_OFF_NVBITS, 32'h3);
    chkMap(28'h0000000, 1'b0, 4'h2);
    cmd(`FNVC_CMD_SET_LOCK, 24'h3);
    `CHK("locks", 32'h8, lockBits)
    cmd(`FNVC_CMD_CLR_LOCK, 24'h3);
    chkRd(`FNVC_OFF_LOCK, 32'h0);
    cmd(`FNVC_CMD_SET_LOCK, 24'h5);
    `CHK("protect", 1'b0, readProtected)
    cmd(`FNVC_CMD_SET_PROT, 24'h0);
    `CHK("protect", 1'b1, readProtected)
    // A command sent while busy must be refused and change nothing.
    wr(`FNVC_OFF_CMD, {24'h0, `FNVC_CMD_PROG});
    wr(`FNVC_OFF_CMD, {24'h2, `FNVC_CMD_SET_NVBIT});
    chkRd(`FNVC_OFF_STATUS, 32'hB);
    idle();
    chkRd(`FNVC_OFF_NVBITS, 32'h3);
    cmd(`FNVC_CMD_PROG_NOERASE, 24'h1);
    cmd(`FNVC_CMD_FULL_ERASE, 24'h0);
    `CHK("protect", 1'b1, readProtected)
    // A pin pulse shorter than the qualification time is a glitch.
    i_fnvc_erase_programmer.hold_pin(10);
    repeat (10) @(posedge sys_clk);
    `CHK("detector", 1'b1, brownoutDetectorEn)
    `CHK("protect", 1'b1, readProtected)
    i_fnvc_erase_programmer.hold_pin(25);
    idle();
    chkRd(`FNVC_OFF_NVBITS, 32'h0);
    `CHK("detector", 1'b0, brownoutDetectorEn)
    `CHK("reset enable", 1'b0, brownoutResetEn)
    `CHK("protect", 1'b0, readProtected)
    `CHK("locks", 32'h0, lockBits)
    chkRd(`FNVC_OFF_CALIB, 32'h5A3C);
    finish_test();
  end
endmodule

// ===== verilog/fnvc_nvm_ctrl.sv
// Flash non-volatile configuration controller: protection, general purpose
// non-volatile bits, lock bits, page write buffer, timed commands, map decode.
// Assumes Avalon-MM master on sys_clk and an erase pin asynchronous to sys_clk.
`include "fnvc_params.svh"
module fnvc_nvm_ctrl #(
  parameter int LOCK_BITS = 32,
  parameter int BUF_WORDS = 64,
  parameter int PAGES_PER_BANK = 1024,
  parameter int PROG_CYCLES = `FNVC_US_CYCLES(`FNVC_PROG_US),
  parameter int PROG_NOERASE_CYCLES = `FNVC_US_CYCLES(`FNVC_PROG_NOERASE_US),
  parameter int ERASE_CYCLES = `FNVC_US_CYCLES(`FNVC_FULL_ERASE_US),
  parameter int ERASE_PIN_CYCLES = `FNVC_US_CYCLES(`FNVC_ERASE_PIN_US),
  parameter logic [15:0] CALIB_VALUE = `FNVC_CALIB_RESET
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM register slave.
  input wire fnvc_pkg::fnvc_bus_req_t busReq,
  output fnvc_pkg::fnvc_bus_rsp_t busRsp,
  // External erase pin and processor fetch decode.
  input wire logic erasePin,
  input wire fnvc_pkg::fnvc_fetch_t fetch,
  output fnvc_pkg::fnvc_region_t region,
  // Configuration outputs.
  output logic brownoutDetectorEn,
  output logic brownoutResetEn,
  output logic readProtected,
  output logic [LOCK_BITS-1:0] lockBits,
  output logic [15:0] calibBits
);
  import fnvc_pkg::*;

  localparam int CW = 32;
  localparam int BW = $clog2(BUF_WORDS);
  localparam int PAGE_W = $clog2(2 * PAGES_PER_BANK);

  typedef struct packed {
    fnvc_state_t state;
    logic [CW-1:0] count;
    logic [CW-1:0] pinCount;
    logic [1:0] pinSync;
    logic erasePinSeen;
    logic eraseArmed;
    logic protect;
    logic [2:0] nvBits;
    logic [LOCK_BITS-1:0] lock;
    logic [BW-1:0] bufAddr;
    logic [PAGE_W-1:0] page;
    logic [7:0] cmd;
    logic cmdError;
    fnvc_bus_rsp_t rsp;
    fnvc_region_t region;
  } fnvc_regs_t;

  fnvc_regs_t r;
  fnvc_regs_t next_r;
  logic [31:0] pageBuf [BUF_WORDS];
  logic bufWrite;

  // ==========================================================================
  // Page write buffer.
  // ==========================================================================
  // The buffer is plain storage with no reset; software fills it before a command.
  always_ff @(posedge sys_clk) begin
    if (bufWrite) begin
      pageBuf[r.bufAddr] <= busReq.writedata;
    end
  end

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  always_comb begin
    logic [7:0] op;
    logic [PAGE_W-1:0] arg;
    logic busy;
    logic lockHit;
    op = busReq.writedata[7:0];
    arg = busReq.writedata[8 +: PAGE_W];
    next_r = r;
    bufWrite = 1'b0;
    busy = (r.state != FNVC_IDLE);
    lockHit = r.lock[arg[PAGE_W-1 -: $clog2(LOCK_BITS)]];
    next_r.rsp.waitrequest = 1'b1;
    next_r.rsp.readdata = 32'h0000_0000;

    // Erase pin: two flip-flop synchroniser, then qualification count.
    next_r.pinSync = {r.pinSync[0], erasePin};
    if (!r.pinSync[1]) begin
      next_r.pinCount = '0;
      next_r.erasePinSeen = 1'b0;
    end else if (r.pinCount < CW'(ERASE_PIN_CYCLES)) begin
      next_r.pinCount = r.pinCount + CW'(1);
    end else if (!r.erasePinSeen) begin
      // Qualified assertion: clear bits 0 and 1, arm the erase.
      next_r.erasePinSeen = 1'b1;
      next_r.nvBits[`FNVC_NV_BROWNOUT_EN] = 1'b0;
      next_r.nvBits[`FNVC_NV_BROWNOUT_RST] = 1'b0;
      next_r.eraseArmed = 1'b1;
    end

    // Timed operations.
    case (r.state)
      FNVC_IDLE: begin
        if (r.eraseArmed) begin
          next_r.state = FNVC_ERASE_PIN;
          next_r.count = CW'(ERASE_CYCLES);
        end
      end
      FNVC_BUSY, FNVC_ERASE_PIN: begin
        if (r.count > CW'(1)) begin
          next_r.count = r.count - CW'(1);
        end else begin
          next_r.state = FNVC_IDLE;
          if (r.cmd == `FNVC_CMD_FULL_ERASE || r.state == FNVC_ERASE_PIN) begin
            next_r.lock = '0;
            if (r.eraseArmed) begin
              next_r.protect = 1'b0;
              next_r.eraseArmed = 1'b0;
            end
          end
        end
      end
      default: begin
        next_r.state = FNVC_IDLE;
      end
    endcase

    // Avalon slave: one wait cycle, answer on the second edge.
    // Writes act only at the edge where the master sees waitrequest low.
    if ((busReq.read || busReq.write) && r.rsp.waitrequest) begin
      next_r.rsp.waitrequest = 1'b0;
      if (busReq.read) begin
        case (busReq.address)
          `FNVC_OFF_STATUS:
            next_r.rsp.readdata = {28'h0, r.cmdError, r.eraseArmed, r.protect, busy};
          `FNVC_OFF_NVBITS: next_r.rsp.readdata = {29'h0, r.nvBits};
          `FNVC_OFF_CALIB: next_r.rsp.readdata = {16'h0, CALIB_VALUE};
          `FNVC_OFF_LOCK: next_r.rsp.readdata = 32'(r.lock);
          `FNVC_OFF_BUFADDR: next_r.rsp.readdata = 32'(r.bufAddr);
          default: next_r.rsp.readdata = 32'h0000_0000;
        endcase
      end
    end
    if (busReq.write && !busReq.read && !r.rsp.waitrequest) begin
      begin
        case (busReq.address)
          `FNVC_OFF_BUFADDR: next_r.bufAddr = busReq.writedata[BW-1:0];
          `FNVC_OFF_BUFDATA: begin
            bufWrite = 1'b1;
            next_r.bufAddr = r.bufAddr + BW'(1);
          end
          `FNVC_OFF_CMD: begin
            next_r.cmdError = 1'b0;
            if (busy || r.eraseArmed) begin
              next_r.cmdError = 1'b1;
            end else begin
              next_r.cmd = op;
              next_r.page = arg;
              case (op)
                `FNVC_CMD_SET_PROT: next_r.protect = 1'b1;
                `FNVC_CMD_SET_NVBIT: next_r.nvBits[arg[1:0]] = 1'b1;
                `FNVC_CMD_CLR_NVBIT: next_r.nvBits[arg[1:0]] = 1'b0;
                `FNVC_CMD_SET_LOCK: next_r.lock[arg[$clog2(LOCK_BITS)-1:0]] = 1'b1;
                `FNVC_CMD_CLR_LOCK: next_r.lock[arg[$clog2(LOCK_BITS)-1:0]] = 1'b0;
                `FNVC_CMD_PROG, `FNVC_CMD_PROG_NOERASE: begin
                  if (lockHit) begin
                    next_r.cmdError = 1'b1;
                  end else begin
                    next_r.state = FNVC_BUSY;
                    next_r.count = (op == `FNVC_CMD_PROG) ? CW'(PROG_CYCLES)
                        : CW'(PROG_NOERASE_CYCLES);
                  end
                end
                `FNVC_CMD_FULL_ERASE: begin
                  next_r.state = FNVC_BUSY;
                  next_r.count = CW'(ERASE_CYCLES);
                end
                default: next_r.cmdError = 1'b1;
              endcase
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Address zero decode; 1 MB windows, abort above 0x003F_FFFF.
    next_r.region = '0;
    case (fetch.addr[27:20])
      8'h00: begin
        next_r.region.sramSel = fetch.remapped;
        next_r.region.flashSel = !fetch.remapped && r.nvBits[`FNVC_NV_BOOT_FLASH];
        next_r.region.romSel = !fetch.remapped && !r.nvBits[`FNVC_NV_BOOT_FLASH];
      end
      8'h01: next_r.region.flashSel = 1'b1;
      8'h02: next_r.region.sramSel = 1'b1;
      8'h03: next_r.region.romSel = 1'b1;
      default: next_r.region.abort = 1'b1;
    endcase
  end

  // ==========================================================================
  // State register.
  // ==========================================================================
  // Non-volatile bits live in flash cells; reset models power-up recall.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.state <= FNVC_IDLE;
      r.nvBits <= `FNVC_NV_RESET;
      r.rsp.waitrequest <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign busRsp = r.rsp;
  assign region = r.region;
  assign brownoutDetectorEn = r.nvBits[`FNVC_NV_BROWNOUT_EN];
  assign brownoutResetEn = r.nvBits[`FNVC_NV_BROWNOUT_RST];
  assign readProtected = r.protect;
  assign lockBits = r.lock;
  assign calibBits = CALIB_VALUE;

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  property p_prot_set;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(r.protect) |-> $past(busReq.write) && $past(busReq.writedata[7:0]) == `FNVC_CMD_SET_PROT;
  endproperty
  a_prot_set: assert property (p_prot_set) else $error("Protection set without command.");

  property p_prot_clr;
    @(posedge sys_clk) disable iff (!arst_n)
    $fell(r.protect) |-> $past(r.state) == FNVC_ERASE_PIN;
  endproperty
  a_prot_clr: assert property (p_prot_clr) else $error("Protection cleared without erase.");

  property p_bod;
    @(posedge sys_clk) disable iff (!arst_n)
    brownoutDetectorEn == r.nvBits[0] && brownoutResetEn == r.nvBits[1];
  endproperty
  a_bod: assert property (p_bod) else $error("Brownout enables disagree with bits.");

  property p_nv_cmd;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(r.nvBits[2]) |-> $past(busReq.write) && !$past(r.rsp.waitrequest);
  endproperty
  a_nv_cmd: assert property (p_nv_cmd) else $error("Boot bit set without a write.");

  property p_pin_clear;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(r.erasePinSeen) |=> !r.nvBits[0] && !r.nvBits[1];
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("Erase pin left brownout on.");

  property p_pin_qual;
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(r.erasePinSeen) |-> $past(r.pinSync[1], 2) && $past(r.pinCount) == CW'(ERASE_PIN_CYCLES);
  endproperty
  a_pin_qual: assert property (p_pin_qual) else $error("Erase pin acted unqualified.");

  property p_calib;
    @(posedge sys_clk) disable iff (!arst_n)
    calibBits == CALIB_VALUE;
  endproperty
  a_calib: assert property (p_calib) else $error("Calibration bits changed.");

  property p_abort;
    @(posedge sys_clk) disable iff (!arst_n)
    (fetch.addr[27:20] > 8'h03) |=> region.abort && !region.flashSel;
  endproperty
  a_abort: assert property (p_abort) else $error("Undefined area did not abort.");

  property p_boot;
    @(posedge sys_clk) disable iff (!arst_n)
    (fetch.addr[27:20] == 8'h00 && !fetch.remapped) |=> region.romSel == !$past(r.nvBits[2]);
  endproperty
  a_boot: assert property (p_boot) else $error("Boot mapping wrong.");

  property p_bus_ans;
    @(posedge sys_clk) disable iff (!arst_n)
    ($rose(busReq.read) || $rose(busReq.write)) |-> ##1 !busRsp.waitrequest;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("Bus answer late.");
endmodule

// ===== verilog/fnvc_params.svh
// Constants of the flash non-volatile configuration controller.
// Assumes a 40 MHz system clock; included by the package and the design.
`ifndef FNVC_PARAMS_SVH
`define FNVC_PARAMS_SVH
`define FNVC_CLK_HZ 40000000
// Register word offsets on the Avalon word bus.
`define FNVC_OFF_CMD 4'h0
`define FNVC_OFF_STATUS 4'h1
`define FNVC_OFF_NVBITS 4'h2
`define FNVC_OFF_CALIB 4'h3
`define FNVC_OFF_LOCK 4'h4
`define FNVC_OFF_BUFADDR 4'h5
`define FNVC_OFF_BUFDATA 4'h6
// Command codes written to the command register bits 7:0.
`define FNVC_CMD_PROG 8'h01
`define FNVC_CMD_PROG_NOERASE 8'h02
`define FNVC_CMD_FULL_ERASE 8'h08
`define FNVC_CMD_SET_PROT 8'h0B
`define FNVC_CMD_SET_NVBIT 8'h0C
`define FNVC_CMD_CLR_NVBIT 8'h0D
`define FNVC_CMD_SET_LOCK 8'h0E
`define FNVC_CMD_CLR_LOCK 8'h0F
// Non-volatile bit positions.
`define FNVC_NV_BROWNOUT_EN 0
`define FNVC_NV_BROWNOUT_RST 1
`define FNVC_NV_BOOT_FLASH 2
// Reset values.
`define FNVC_NV_RESET 3'h0
`define FNVC_CALIB_RESET 16'h5A3C
// Timing in microseconds, as printed, and derived counts.
`define FNVC_PROG_US 6000
`define FNVC_PROG_NOERASE_US 3000
`define FNVC_FULL_ERASE_US 15000
`define FNVC_ERASE_PIN_US 200000
`define FNVC_US_CYCLES(us) ((us) * (`FNVC_CLK_HZ / 1000000))
`endif

// ===== verilog/fnvc_pkg.sv
// Types of the flash non-volatile configuration controller.
// Assumes fnvc_params.svh is on the include path.
`include "fnvc_params.svh"
package fnvc_pkg;
  typedef enum logic [1:0] {
    FNVC_IDLE,
    FNVC_BUSY,
    FNVC_ERASE_PIN
  } fnvc_state_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } fnvc_bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } fnvc_bus_rsp_t;

  typedef struct packed {
    logic [27:0] addr;
    logic remapped;
  } fnvc_fetch_t;

  typedef struct packed {
    logic flashSel;
    logic sramSel;
    logic romSel;
    logic abort;
  } fnvc_region_t;
endpackage
